// File: common/serial_port_pkg.sv
// Package: register map, field positions, reset values and states
// Assumes: shared by the serial port top and its helper modules
package serial_port_pkg;
  // ***********************
  // Register byte offsets
  // ***********************
  localparam logic [7:0] OFS_TXCS = 8'h00;
  localparam logic [7:0] OFS_RXCS = 8'h04;
  localparam logic [7:0] OFS_TXD  = 8'h08;
  localparam logic [7:0] OFS_RXD  = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_IST  = 8'h14;
  localparam logic [7:0] OFS_IMSK = 8'h18;
  // ***********************
  // Field positions
  // ***********************
  localparam int TX_MASTER = 7;
  localparam int TX_NINE   = 6;
  localparam int TX_EN     = 5;
  localparam int TX_SYNC   = 4;
  localparam int TX_EMPTY  = 1;
  localparam int TX_NINTH  = 0;
  localparam int RX_PORT_ENABLE_BIT   = 7;
  localparam int RX_NINE   = 6;
  localparam int RX_SINGLE = 5;
  localparam int RX_CONT   = 4;
  localparam int RX_ADDR   = 3;
  localparam int RX_FRAMING_ERROR_FLAG   = 2;
  localparam int RX_OVERRUN_ERROR_FLAG   = 1;
  localparam int RX_NINTH  = 0;
  localparam int IRQ_RX    = 0;
  localparam int IRQ_TXE   = 1;
  localparam int IRQ_OVR   = 2;
  localparam int IRQ_FRM   = 3;
  localparam int IRQ_W     = 4;
  // ***********************
  // Reset values and masks
  // ***********************
  localparam logic [7:0]  TXCS_RST   = 8'h02;
  localparam logic [7:0]  TXCS_WMASK = 8'hf1;
  localparam logic [7:0]  RXCS_RST   = 8'h00;
  localparam logic [7:0]  RXCS_WMASK = 8'hf8;
  localparam logic [15:0] BAUD_RST   = 16'h0019;
  localparam logic [3:0]  IRQ_RST    = 4'h0;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;
endpackage : serial_port_pkg

// File: common/tx_link_if.sv
// Interface: control top to transmit shifter
// Assumes: one clock domain, driven by the top module
`timescale 1ns/10ps
interface tx_link_if;
  logic       load;
  logic [8:0] data;
  logic       nine;
  logic       sync;
  logic       tick;
  logic       busy;
  logic       line;
  modport ctrl (output load, data, nine, sync, tick, input busy, line);
  modport shft (input load, data, nine, sync, tick, output busy, line);
endinterface : tx_link_if

// File: verilog/pin_sync.sv
// Three-flop synchroniser for pins, with agreement filter
// Assumes: inputs are asynchronous to clk
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] f1_r;
  logic [W-1:0] f2_r;
  logic [W-1:0] f3_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f1_r <= '1;
      f2_r <= '1;
      f3_r <= '1;
    end else if (ce) begin
      f1_r <= d;
      f2_r <= f1_r;
      f3_r <= f2_r;
    end
  end
  // Idle lines are high, so reset to one
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) q_r[i] <= 1'b1;
      else if (ce && (f2_r[i] == f3_r[i])) q_r[i] <= f3_r[i];
    end
  end
  assign q = q_r;
endmodule : pin_sync

// File: verilog/tx_shifter.sv
// Transmit shift register, async or sync framing
// Assumes: tick marks each bit time; clr holds it idle
`timescale 1ns/10ps
module tx_shifter
  import serial_port_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic clr,
  // Link to control
  tx_link_if.shft   lk
);
  logic [10:0] sh_r;
  logic [3:0]  cnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_r  <= '1;
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (clr) begin
        sh_r  <= '1;
        cnt_r <= 4'h0;
      end else if (lk.load && cnt_r == 4'h0) begin
        if (lk.sync) begin
          sh_r  <= {2'b11, lk.data};
          cnt_r <= lk.nine ? 4'h9 : 4'h8;
        end else begin
          // Ninth bit replaced by a stop bit in 8-bit mode
          sh_r  <= {1'b1, lk.nine ? lk.data[8] : 1'b1, lk.data[7:0], 1'b0};
          cnt_r <= lk.nine ? 4'hb : 4'ha;
        end
      end else if (lk.tick && cnt_r != 4'h0) begin
        sh_r  <= {1'b1, sh_r[10:1]};
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign lk.busy = (cnt_r != 4'h0);
  assign lk.line = lk.busy ? sh_r[0] : 1'b1;
endmodule : tx_shifter

// File: verilog/serial_port_tx_rx_control.sv
// Serial port control and status block with Wishbone registers
// Assumes: classic Wishbone master, single 10 MHz clock, pins async
`timescale 1ns/10ps
module serial_port_tx_rx_control
  import serial_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Receive data pin
  input  wire logic        receive_data_pin_i,
  output logic             receive_data_pin_o,
  output logic             receive_data_pin_oe,
  // Transmit clock pin
  input  wire logic        transmit_clock_pin_i,
  output logic             transmit_clock_pin_o,
  output logic             transmit_clock_pin_oe,
  // Interrupt
  output logic             irq
);
  // ***********************
  // Registers and state
  // ***********************
  logic [7:0]        txcs_r;
  logic [7:0]        rxcs_r;
  logic [15:0]       bdiv_r;
  logic [15:0]       bcnt_r;
  logic [15:0]       rcnt_r;
  logic [8:0]        txd_r;
  logic              txpend_r;
  logic [7:0]        rxbuf_r;
  logic              rxfull_r;
  logic              ninth_r;
  logic              framing_error_flag_r;
  logic              overrun_error_flag_r;
  logic [8:0]        rsr_r;
  logic [3:0]        idx_r;
  rx_state_e         rst_r;
  logic [IRQ_W-1:0]  ist_r;
  logic [IRQ_W-1:0]  ist_nxt;
  logic [IRQ_W-1:0]  imsk_r;
  logic              busy_d_r;
  logic              ck_d_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic [31:0]       rdata;
  logic [1:0]        pins;
  logic              rxd;
  logic              ckin;
  tx_link_if         lk ();

  // Mode decode
  logic port_enable_bit, sync, master, rx_en, nine, tick, half;
  logic rx_busy, samp, fin, fin_framing_error_flag, accept, ck_rise;
  logic req, wr, rd;
  assign port_enable_bit   = rxcs_r[RX_PORT_ENABLE_BIT];
  assign sync   = txcs_r[TX_SYNC];
  assign master = txcs_r[TX_MASTER];
  assign nine   = rxcs_r[RX_NINE];
  // Single receive only counts in sync master; continuous wins
  assign rx_en  = port_enable_bit && !overrun_error_flag_r && (rxcs_r[RX_CONT] ||
                  (sync && master && rxcs_r[RX_SINGLE]));
  assign rx_busy = (rst_r != RX_IDLE);
  assign tick   = (bcnt_r == 16'h0000);
  assign half   = (bcnt_r == (bdiv_r >> 1));
  assign ck_rise = ckin && !ck_d_r;

  // ***********************
  // Pin synchronisers
  // ***********************
  pin_sync #(.W(2)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      ({transmit_clock_pin_i, receive_data_pin_i}),
    .q      (pins)
  );
  assign rxd  = pins[0];
  assign ckin = pins[1];

  // ***********************
  // Transmitter
  // ***********************
  assign lk.data = {txcs_r[TX_NINTH], txd_r[7:0]};
  assign lk.nine = txcs_r[TX_NINE];
  assign lk.sync = sync;
  // Slave transmit shifts on the remote clock falling edge
  assign lk.tick = (sync && !master) ? (ck_d_r && !ckin) : tick;
  // Receive requests hold off transmit in sync mode
  assign lk.load = txpend_r && txcs_r[TX_EN] && port_enable_bit &&
                   !(sync && (rx_en || rx_busy));

  tx_shifter u_tx (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clr    (!port_enable_bit),
    .lk     (lk)
  );

  // ***********************
  // Pins
  // ***********************
  always_comb begin
    transmit_clock_pin_oe = port_enable_bit && (!sync || master);
    receive_data_pin_oe   = port_enable_bit && sync && lk.busy && !rx_busy;
    receive_data_pin_o    = lk.line;
    if (!port_enable_bit) begin
      // Idle level at once, not one cycle later when the shifter clears
      transmit_clock_pin_o = 1'b1;
    end else if (sync) begin
      // Master clock low in first half of each bit while active
      transmit_clock_pin_o = !((lk.busy || rx_busy) &&
                               (bcnt_r > (bdiv_r >> 1)));
    end else begin
      transmit_clock_pin_o = lk.line;
    end
  end

  // ***********************
  // Baud timing
  // ***********************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_r <= 16'h0000;
      ck_d_r <= 1'b1;
    end else if (ce) begin
      ck_d_r <= ckin;
      // Restart on load so the start bit lasts a full bit time
      if (!port_enable_bit || tick || (lk.load && !lk.busy)) bcnt_r <= bdiv_r;
      else bcnt_r <= bcnt_r - 16'h0001;
    end
  end

  // ***********************
  // Receiver
  // ***********************
  // Sample point: async phase counter, master mid-bit, slave edge
  always_comb begin
    if (!sync) samp = (rcnt_r == 16'h0000);
    else if (master) samp = half;
    else samp = ck_rise;
  end
  always_comb begin
    fin      = 1'b0;
    fin_framing_error_flag = 1'b0;
    if (sync && rst_r == RX_DATA && samp && idx_r == (nine ? 4'h8 : 4'h7)) begin
      fin = 1'b1;
    end
    if (!sync && rst_r == RX_STOP && samp) begin
      fin      = 1'b1;
      fin_framing_error_flag = !rxd;
    end
  end
  // Address filter only in async 9-bit mode
  assign accept = !(!sync && nine && rxcs_r[RX_ADDR] && !rsr_r[8]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_r  <= RX_IDLE;
      rcnt_r <= 16'h0000;
      idx_r  <= 4'h0;
      rsr_r  <= 9'h000;
    end else if (ce) begin
      rcnt_r <= (rcnt_r == 16'h0000) ? bdiv_r : rcnt_r - 16'h0001;
      if (!rx_en) begin
        rst_r <= RX_IDLE;
      end else begin
        unique case (rst_r)
          RX_IDLE: begin
            idx_r <= 4'h0;
            rsr_r <= 9'h000;
            if (sync) begin
              rst_r <= RX_DATA;
            end else if (!rxd) begin
              rst_r  <= RX_START;
              rcnt_r <= bdiv_r >> 1;
            end
          end
          RX_START: begin
            // Start bit must still be low at its middle
            if (samp) rst_r <= rxd ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            if (samp) begin
              rsr_r[idx_r] <= rxd;
              if (idx_r == (nine ? 4'h8 : 4'h7)) begin
                rst_r <= sync ? RX_IDLE : RX_STOP;
              end else begin
                idx_r <= idx_r + 4'h1;
              end
            end
          end
          RX_STOP: begin
            if (samp) rst_r <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ***********************
  // Receive buffer and flags
  // ***********************
  // The ninth bit is only stored; parity checking is left to software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxbuf_r  <= 8'h00;
      rxfull_r <= 1'b0;
      ninth_r  <= 1'b0;
      framing_error_flag_r   <= 1'b0;
      overrun_error_flag_r   <= 1'b0;
    end else if (ce) begin
      if (!port_enable_bit) begin
        rxfull_r <= 1'b0;
        framing_error_flag_r   <= 1'b0;
        overrun_error_flag_r   <= 1'b0;
      end else begin
        if (rd && wb_adr_i == OFS_RXD) rxfull_r <= 1'b0;
        if (!rxcs_r[RX_CONT]) overrun_error_flag_r <= 1'b0;
        if (fin && accept) begin
          if (rxfull_r && !(rd && wb_adr_i == OFS_RXD)) begin
            overrun_error_flag_r <= rxcs_r[RX_CONT];
          end else begin
            rxbuf_r  <= rsr_r[7:0];
            ninth_r  <= nine ? rsr_r[8] : 1'b0;
            framing_error_flag_r   <= fin_framing_error_flag;
            rxfull_r <= 1'b1;
          end
        end
      end
    end
  end

  // ***********************
  // Wishbone slave
  // ***********************
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign rd  = req && !wb_we_i;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_TXCS: rdata[7:0] = (txcs_r & TXCS_WMASK) |
                             {6'h00, !lk.busy, 1'b0};
      OFS_RXCS: rdata[7:0] = {rxcs_r[7:3], framing_error_flag_r, overrun_error_flag_r, ninth_r && nine};
      OFS_TXD:  rdata[7:0] = txd_r[7:0];
      OFS_RXD:  rdata[7:0] = rxbuf_r;
      OFS_BAUD: rdata[15:0] = bdiv_r;
      OFS_IST:  rdata[IRQ_W-1:0] = ist_r;
      OFS_IMSK: rdata[IRQ_W-1:0] = imsk_r;
      default:  rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce) begin
      ack_r <= req;
      if (rd) dat_r <= rdata;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Control registers; single receive clears itself on completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txcs_r <= TXCS_RST & TXCS_WMASK;
      rxcs_r <= RXCS_RST;
      bdiv_r <= BAUD_RST;
      imsk_r <= IRQ_RST;
    end else if (ce) begin
      if (fin && sync && master && !rxcs_r[RX_CONT]) begin
        rxcs_r[RX_SINGLE] <= 1'b0;
      end
      if (wr) begin
        unique case (wb_adr_i)
          OFS_TXCS: txcs_r <= wb_dat_i[7:0] & TXCS_WMASK;
          OFS_RXCS: rxcs_r <= wb_dat_i[7:0] & RXCS_WMASK;
          OFS_BAUD: begin
            if (wb_sel_i[1]) bdiv_r <= wb_dat_i[15:0];
            else bdiv_r[7:0] <= wb_dat_i[7:0];
          end
          OFS_IMSK: imsk_r <= wb_dat_i[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Transmit holding register, taken by the shifter when idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_r    <= 9'h000;
      txpend_r <= 1'b0;
    end else if (ce) begin
      if (!port_enable_bit) begin
        txpend_r <= 1'b0;
      end else if (wr && wb_adr_i == OFS_TXD) begin
        txd_r    <= {1'b0, wb_dat_i[7:0]};
        txpend_r <= 1'b1;
      end else if (lk.load && !lk.busy) begin
        txpend_r <= 1'b0;
      end
    end
  end

  // ***********************
  // Interrupts
  // ***********************
  // Set beats a write-one clear in the same cycle
  always_comb begin
    ist_nxt = ist_r;
    if (wr && wb_adr_i == OFS_IST) ist_nxt = ist_r & ~wb_dat_i[IRQ_W-1:0];
    if (port_enable_bit && fin && accept && !rxfull_r) ist_nxt[IRQ_RX] = 1'b1;
    if (port_enable_bit && fin && accept && rxfull_r) ist_nxt[IRQ_OVR] = 1'b1;
    if (port_enable_bit && fin && accept && fin_framing_error_flag) ist_nxt[IRQ_FRM] = 1'b1;
    if (busy_d_r && !lk.busy) ist_nxt[IRQ_TXE] = 1'b1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_r    <= IRQ_RST;
      busy_d_r <= 1'b0;
    end else if (ce) begin
      ist_r    <= ist_nxt;
      busy_d_r <= lk.busy;
    end
  end
  assign irq = |(ist_r & imsk_r);
endmodule : serial_port_tx_rx_control

// File: tb/serial_port_tx_rx_control_properties.sv
// Checker: bus timing, pin ownership and readback properties
// Assumes: sees the top ports only; bound after the module
`timescale 1ns/10ps
module serial_port_tx_rx_control_properties
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins and interrupt
  input wire logic        receive_data_pin_oe,
  input wire logic        transmit_clock_pin_o,
  input wire logic        transmit_clock_pin_oe,
  input wire logic        irq
);
  // ****
  // Shadow of written control bits
  // ****
  logic       port_enable_bit_r, rx9_r, cont_r, sync_r;
  logic [3:0] mask_r;
  wire        take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  wire        wr_w   = take_w && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {port_enable_bit_r, rx9_r, cont_r} <= 3'b000;
    end else if (wr_w && wb_adr_i == OFS_RXCS) begin
      {port_enable_bit_r, rx9_r, cont_r} <= {wb_dat_i[RX_PORT_ENABLE_BIT], wb_dat_i[RX_NINE], wb_dat_i[RX_CONT]};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sync_r <= 1'b0;
    else if (wr_w && wb_adr_i == OFS_TXCS) sync_r <= wb_dat_i[TX_SYNC];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) mask_r <= 4'h0;
    else if (wr_w && wb_adr_i == OFS_IMSK) mask_r <= wb_dat_i[3:0];
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_next;
    take_w |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o && ce |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_off_no_drive;
    !port_enable_bit_r |-> !receive_data_pin_oe && !transmit_clock_pin_oe;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("pin driven while port off");
  property p_off_idle;
    !port_enable_bit_r |-> transmit_clock_pin_o;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("line not idle while port off");
  property p_pins_owned;
    port_enable_bit_r && !sync_r |-> transmit_clock_pin_oe;
  endproperty
  a_pins_owned: assert property (p_pins_owned) else $error("async line not driven");
  property p_rx_pin_in;
    !sync_r |-> !receive_data_pin_oe;
  endproperty
  a_rx_pin_in: assert property (p_rx_pin_in) else $error("data pin driven in async");
  property p_nine_off;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_RXCS) && !rx9_r |-> !wb_dat_o[RX_NINTH];
  endproperty
  a_nine_off: assert property (p_nine_off) else $error("ninth bit set in 8-bit mode");
  property p_ovr_clear;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_RXCS) && !cont_r |-> !wb_dat_o[RX_OVERRUN_ERROR_FLAG];
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept with receive off");
  property p_unmapped;
    wb_ack_o && $past(!wb_we_i && wb_adr_i > OFS_IMSK) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_masked;
    mask_r == 4'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
endmodule : serial_port_tx_rx_control_properties
bind serial_port_tx_rx_control serial_port_tx_rx_control_properties u_serial_port_tx_rx_control_properties (
  .clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .receive_data_pin_oe, .transmit_clock_pin_o, .transmit_clock_pin_oe, .irq);

// File: tb/serial_node_model.sv
// Remote serial node: sends async frames, captures the far line
// Assumes: BIT clocks a bit; its line idles high like a pulled-up wire
`timescale 1ns/10ps
module serial_node_model #(
  parameter int BIT = 8
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // ****
  // Frame out: start, n bits LSB first, stop (0 forces a framing fault)
  // ****
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (BIT) @(posedge clk);
    end
    rx_line <= stop;
    repeat (BIT) @(posedge clk);
    rx_line <= 1'b1;
  endtask : send
  // ****
  // Frame in: bounded wait for start, sample mid-bit
  // ****
  task automatic recv(output logic [8:0] d, input int n);
    int k;
    d = 9'h0;
    k = 0;
    while (tx_line !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = tx_line;
    end
  endtask : recv
endmodule : serial_node_model

// File: tb/serial_port_tx_rx_control_tb_top.sv
// Testbench: registers, async receive and transmit, sync precedence
// Assumes: node model on the pins; baud divisor BIT-1, one bit = BIT clocks
`timescale 1ns/10ps
module serial_port_tx_rx_control_tb_top
  import serial_port_pkg::*;
;
  localparam int BIT = 8;
  logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, rx_o, rx_oe, tx_o, tx_oe, irq, node_line;
  logic [31:0] seed = 32'hc559ff89, r;
  logic [8:0]  d, got;
  logic [7:0]  cfg [6] = '{8'h90, 8'h80, 8'hd8, 8'hd8, 8'hd0, 8'h98};
  int          error_cnt = 0, check_count = 0;
  wire         rx_pin = rx_oe ? rx_o : node_line;
  always #50 clk = ~clk;
  serial_port_tx_rx_control u_serial_port_tx_rx_control (
    .clk, .resetn, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .receive_data_pin_i(rx_pin), .receive_data_pin_o(rx_o), .receive_data_pin_oe(rx_oe),
    .transmit_clock_pin_i(1'b1), .transmit_clock_pin_o(tx_o), .transmit_clock_pin_oe(tx_oe), .irq);
  serial_node_model #(.BIT(BIT)) u_serial_node_model (.clk, .tx_line(tx_o), .rx_line(node_line));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  // Held until ack is sampled; a slave that never answers is flagged, not waited on forever
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, v, s};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    ck({31'h0, n >= 20}, 32'h0);
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    ck(q & m, e);
  endtask : rc
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rc(OFS_TXCS, 32'hff, {24'h0, TXCS_RST});
    rc(OFS_RXCS, 32'hff, {24'h0, RXCS_RST});
    rc(OFS_BAUD, 32'hffff, {16'h0, BAUD_RST});
    rc(8'h1c, 32'hffffffff, 32'h0);
    ck({30'h0, tx_oe, rx_oe}, 32'h0);
    // Clock enable low: a raised request must wait, then be answered
    ce <= 1'b0;
    fork
      rc(OFS_RXCS, 32'hff, 32'h0);
      begin
        repeat (5) @(posedge clk);
        ck({31'h0, ack}, 32'h0);
        ce <= 1'b1;
      end
    join
    bus(1'b1, OFS_RXCS, 32'h90, 4'h2);
    rc(OFS_RXCS, 32'hff, 32'h0);
    bus(1'b1, OFS_BAUD, BIT - 1, 4'h3);
    bus(1'b1, OFS_IMSK, 32'h1, 4'h1);
    // Receive modes: plain, receiver off, address filter, parity use, 8-bit ignore
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_RXCS, {24'h0, cfg[i]}, 4'h1);
      ck({31'h0, tx_oe}, 32'h1);
      r = xs();
      d[7:0] = r[7:0];
      d[8] = (i == 3) ? 1'b1 : (i == 4) ? ^d[7:0] : 1'b0;
      u_serial_node_model.send(d, cfg[i][RX_NINE] ? 9 : 8, 1'b1);
      repeat (6) @(posedge clk);
      rc(OFS_IST, 32'h1, {31'h0, i != 1 && i != 2});
      if (i != 1 && i != 2) begin
        ck({31'h0, irq}, 32'h1);
        rc(OFS_RXD, 32'hff, {24'h0, d[7:0]});
        rc(OFS_RXCS, 32'h5, {31'h0, cfg[i][RX_NINE] & d[8]});
      end
      bus(1'b1, OFS_IMSK, 32'h0, 4'h1);
      ck({31'h0, irq}, 32'h0);
      bus(1'b1, OFS_IMSK, 32'h1, 4'h1);
      bus(1'b1, OFS_IST, 32'hf, 4'h1);
      ck({31'h0, irq}, 32'h0);
    end
    // Framing fault then a good character
    bus(1'b1, OFS_RXCS, 32'h90, 4'h1);
    r = xs();
    u_serial_node_model.send({1'b0, r[7:0]}, 8, 1'b0);
    repeat (2 * BIT) @(posedge clk);
    rc(OFS_RXCS, 32'h4, 32'h4);
    rc(OFS_RXD, 32'hff, {24'h0, r[7:0]});
    r = xs();
    d = {1'b0, r[7:0]};
    u_serial_node_model.send(d, 8, 1'b1);
    repeat (6) @(posedge clk);
    rc(OFS_RXCS, 32'h4, 32'h0);
    // Overrun: two characters with no read between
    r = xs();
    u_serial_node_model.send({1'b0, r[7:0]}, 8, 1'b1);
    u_serial_node_model.send({1'b0, r[15:8]}, 8, 1'b1);
    repeat (6) @(posedge clk);
    rc(OFS_RXCS, 32'h2, 32'h2);
    bus(1'b1, OFS_RXCS, 32'h80, 4'h1);
    rc(OFS_RXCS, 32'h2, 32'h0);
    rc(OFS_RXD, 32'hff, {24'h0, d[7:0]});
    bus(1'b1, OFS_IST, 32'hf, 4'h1);
    // Transmit, 8 and 9 bits
    for (int n = 0; n < 2; n++) begin
      r = xs();
      d = r[8:0];
      bus(1'b1, OFS_TXCS, {24'h0, 1'b0, n[0], 1'b1, 4'h0, d[8]}, 4'h1);
      bus(1'b1, OFS_TXD, {23'h0, d}, 4'h1);
      fork
        u_serial_node_model.recv(got, 8 + n);
        begin
          repeat (BIT) @(posedge clk);
          rc(OFS_TXCS, 32'h2, 32'h0);
        end
      join
      repeat (2 * BIT) @(posedge clk);
      rc(OFS_TXCS, 32'h2, 32'h2);
      ck({23'h0, got}, {23'h0, n[0] & d[8], d[7:0]});
    end
    // Sync master: receive requests hold transmit back
    bus(1'b1, OFS_RXCS, 32'h90, 4'h1);
    bus(1'b1, OFS_TXCS, 32'hb0, 4'h1);
    bus(1'b1, OFS_TXD, 32'h5a, 4'h1);
    repeat (4 * BIT) @(posedge clk);
    rc(OFS_TXCS, 32'h2, 32'h2);
    bus(1'b1, OFS_RXCS, 32'ha0, 4'h1);
    for (int k = 0; k < 60 && q[RX_SINGLE] !== 1'b0; k++) rc(OFS_RXCS, 32'h0, 32'h0);
    ck({31'h0, q[RX_SINGLE]}, 32'h0);
    bus(1'b1, OFS_RXCS, 32'h00, 4'h1);
    rc(OFS_TXCS, 32'h2, 32'h2);
    ck({30'h0, tx_oe, rx_oe}, 32'h0);
    final_report();
  end
endmodule : serial_port_tx_rx_control_tb_top
